// ==== bench/keypad_model.sv ====
// Purpose: Behavioural detachable keypad unit
// Assumes: Keys change just after the falling clock edge
// Notes: Keys are one-cycle pulses, presence is a level
`timescale 1ns/1ps
module keypad_model (
	// Clock
	input wire logic clk,
	// Keypad pins
	output logic present,
	output logic stop_key,
	output logic clear_key,
	output logic reset_key
);
	// Unplugged at power-on, keys idle
	initial begin
		present = 1'h0;
		stop_key = 1'h0;
		clear_key = 1'h0;
		reset_key = 1'h0;
	end
	// Plug or pull the unit; the operator replugs before any reset
	task plug(input logic p);
		@(negedge clk);
		present = p;
	endtask
	// One key for one cycle: 0 stop, 1 stop clear, 2 reset
	task tap(input int k);
		@(negedge clk);
		stop_key = (k == 0);
		clear_key = (k == 1); // Clears only a stop this unit issued
		reset_key = (k == 2);
		@(negedge clk);
		stop_key = 1'h0;
		clear_key = 1'h0;
		reset_key = 1'h0;
	endtask
endmodule // keypad_model

// ==== bench/reset_keypad_supervisor_tb_top.sv ====
// Purpose: Self-checking bench for the supervisor
// Assumes: Absence limit shortened to 20 cycles
// Notes: Inputs change on the falling clock edge
`timescale 1ns/1ps
module reset_keypad_supervisor_tb_top;
	import rks_pkg::*;
	localparam int LIM = 20; // Short limit keeps the run brief
	logic clk, sys_rst, sup_wr, param_clear, ext_rst, comm_rst, pn_stop, pn_clr, jog, rs485;
	logic usb, flt, run, start, cal_wr, rej, cal_err, drv_rst, shutoff, acc_clr, decel, run_en;
	logic trip, loss, fault, pstop, kp_pres, kp_stop, kp_clr, kp_rst;
	logic [4:0] wdata, setting; // Setting path
	logic [1:0] mode; // Operation mode
	logic [15:0] gain, bias; // Calibration pair
	int failures, check_count; // Tallies
	////////////////////////////////////////////////////////////////
	reset_keypad_supervisor #(.LOSS_LIMIT(LIM)) uut (.clk(clk), .sys_rst(sys_rst),
		.sup_wr(sup_wr), .sup_wdata(wdata), .param_clear(param_clear),
		.supervision_setting(setting), .sup_wr_reject(rej), .external_reset_input(ext_rst),
		.comm_reset_cmd(comm_rst), .keypad_reset_key(kp_rst), .keypad_unit_present(kp_pres),
		.keypad_stop_key(kp_stop), .panel_stop_key(pn_stop), .stop_clear_keypad(kp_clr),
		.stop_clear_panel(pn_clr), .op_mode(mode), .keypad_jog(jog), .rs485_via_keypad(rs485),
		.usb_via_keypad(usb), .fault_trip(flt), .running(run), .start_request(start),
		.cal_wr(cal_wr), .cal_gain_freq(gain), .cal_bias_freq(bias), .cal_write_error(cal_err),
		.drive_reset(drv_rst), .output_shutoff(shutoff), .accum_clear(acc_clr),
		.decel_stop(decel), .run_enable(run_en), .tripped(trip), .keypad_loss_fault(loss),
		.fault_output(fault), .panel_stop_state(pstop));
	keypad_model kp (.clk(clk), .present(kp_pres), .stop_key(kp_stop), .clear_key(kp_clr),
		.reset_key(kp_rst));
	////////////////////////////////////////////////////////////////
	// Compare and tally
	task chk(input logic [4:0] g, input logic [4:0] e, input string m);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	// One-cycle strobe
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'h1;
		@(negedge clk);
		s = 1'h0;
	endtask
	// Setting write
	task wr(input logic [4:0] v);
		wdata = v;
		pulse(sup_wr);
	endtask
	// Wait n falling edges
	task idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	////////////////////////////////////////////////////////////////
	// Legal and illegal setting codes
	task t_setting;
		chk(setting, 5'h0e, "default");
		for (int v = 0; v < 20; v++) begin
			wr(5'(v));
			chk(5'(rej), 5'(((v > 3) && (v < 14)) || (v > 17)), "reject");
		end
		pulse(param_clear);
		chk(setting, 5'h11, "survive clear");
		$display("t_setting done");
	endtask
	// Reset gating, setting 17 first
	task t_reset;
		pulse(ext_rst);
		chk(5'(drv_rst), 5'h00, "pin gated");
		pulse(comm_rst);
		chk(5'(drv_rst), 5'h00, "comm gated");
		kp.tap(2);
		chk(5'(drv_rst), 5'h00, "key idle");
		run = 1'h1; // Reset while running must still coast
		pulse(flt);
		pulse(comm_rst);
		chk({drv_rst, acc_clr, shutoff, trip, fault}, 5'h1c, "comm reset");
		run = 1'h0;
		pulse(flt);
		kp.tap(2);
		chk({drv_rst, acc_clr, trip}, 5'h06, "key reset");
		wr(5'h0e);
		pulse(ext_rst);
		chk({drv_rst, shutoff}, 5'h03, "pin free");
		kp.tap(2);
		chk(5'(drv_rst), 5'h00, "key refused");
		$display("t_reset done");
	endtask
	// Keypad loss detection
	task t_loss;
		wr(5'h10);
		idle(LIM + 5);
		chk(5'(loss), 5'h00, "absent at start");
		kp.plug(1'h1);
		kp.plug(1'h0);
		idle(LIM - 6);
		kp.plug(1'h1);
		kp.plug(1'h0);
		idle(LIM - 1);
		chk(5'(loss), 5'h00, "early");
		idle(5);
		chk({loss, trip, fault}, 5'h07, "loss trip");
		kp.plug(1'h1);
		idle(3);
		chk(5'(loss), 5'h01, "held");
		pulse(ext_rst);
		chk({loss, trip}, 5'h00, "cleared");
		rs485 = 1'h1;
		kp.plug(1'h0);
		idle(LIM + 5);
		chk(5'(loss), 5'h00, "rs485");
		rs485 = 1'h0;
		kp.plug(1'h1);
		wr(5'h0e);
		jog = 1'h1;
		kp.plug(1'h0);
		idle(LIM + 5);
		chk({loss, decel}, 5'h01, "jog loss");
		jog = 1'h0;
		kp.plug(1'h1);
		$display("t_loss done");
	endtask
	// Stop latch in each mode
	task t_stop;
		mode = 2'h1;
		kp.tap(0);
		chk({pstop, decel, run_en, fault}, 5'h0c, "stop ext");
		start = 1'h0; // Operator drops the start inputs before the clear
		kp.tap(1);
		chk({pstop, run_en}, 5'h00, "keypad clear");
		start = 1'h1; // Start reasserted only once the stop is cleared
		idle(1);
		chk(5'(run_en), 5'h01, "restart");
		mode = 2'h2;
		pulse(pn_stop);
		kp.tap(1);
		chk(5'(pstop), 5'h01, "wrong unit");
		pulse(pn_clr);
		chk(5'(pstop), 5'h00, "panel clear");
		kp.tap(0);
		pulse(ext_rst);
		chk(5'(pstop), 5'h00, "pin clear");
		wr(5'h02);
		mode = 2'h1;
		kp.tap(0);
		chk({pstop, decel}, 5'h00, "old ext");
		mode = 2'h0;
		kp.tap(0);
		chk({pstop, decel}, 5'h01, "old keypad");
		usb = 1'h1;
		pulse(pn_stop);
		chk(5'(pstop), 5'h01, "usb stop");
		usb = 1'h0;
		pulse(ext_rst);
		$display("t_stop done");
	endtask
	// Gain and bias spacing
	task t_cal;
		gain = 16'h0100;
		bias = 16'h0050;
		pulse(cal_wr);
		chk(5'(cal_err), 5'h00, "wide pair");
		bias = 16'h00f0;
		pulse(cal_wr);
		chk(5'(cal_err), 5'h01, "close pair");
		$display("t_cal done");
	endtask
	////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task conclude;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Clock
	initial begin
		clk = 1'h0;
		forever #(CLK_PERIOD_NS / 2) clk = ~clk;
	end
	// Watchdog, well past the few hundred cycles needed
	initial begin
		#(CLK_PERIOD_NS * 3000);
		failures++;
		conclude();
	end
	// Main sequence
	initial begin
		{sup_wr, param_clear, ext_rst, comm_rst, pn_stop, pn_clr, jog, rs485, usb} = '0;
		{flt, run, cal_wr, wdata, mode, gain, bias} = '0;
		start = 1'h1;
		sys_rst = 1'h1;
		idle(5);
		sys_rst = 1'h0;
		t_setting();
		t_reset();
		t_loss();
		t_stop();
		t_cal();
		conclude();
	end
endmodule // reset_keypad_supervisor_tb_top

// ==== hdl/keypad_loss_timer.sv ====
// Purpose: Counts cycles of keypad absence and flags overrun
// Assumes: Present input is synchronous to clk
// Notes: Arms only after the keypad has been seen present once
`timescale 1ns/1ps
module keypad_loss_timer #(
	parameter int LIMIT = 25000000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Keypad status
	input wire logic present,
	input wire logic enable,
	// Result
	output logic expired
);
	localparam int CW = $clog2(LIMIT + 2);
	logic [CW-1:0] cnt_ff; // Absence cycles
	logic [CW-1:0] nxt_cnt;
	logic seen_ff; // Keypad seen since power-on
	logic done;
	assign done = (cnt_ff > CW'(LIMIT));
	// Counter saturates past the limit; clears on presence [R22]
	assign nxt_cnt = (present || !seen_ff || !enable) ? '0 :
		done ? cnt_ff : cnt_ff + CW'(1);
	////////////////////////////////////////////////////////////////
	// Absence counter; absent-at-power-on never arms it [R11]
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_ff <= '0;
			seen_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			seen_ff <= seen_ff | present;
		end
	end
	assign expired = done;
	a_cnt_clear: assert property (@(posedge clk) disable iff (sys_rst) // [R22]
		present |=> cnt_ff == '0) else $error("count not cleared");
	a_no_arm: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
		!seen_ff |-> !expired) else $error("armed before presence");
endmodule // keypad_loss_timer

// ==== hdl/reset_keypad_supervisor.sv ====
// Purpose: Reset acceptance, keypad loss trip and panel stop control
// Assumes: All inputs synchronous to clk; request inputs are one-cycle pulses
// Notes: Drive core acts on the output pulses and levels given here
// What this block does
// R1: Pin and comm reset share one gate
// R2: Setting accepts only 0-3 and 14-17
// R3: Setting defaults to 14
// R4: Settings 1,3,15,17 reset only when tripped
// R5: Setting writable always, survives parameter clear
// R6: Accepted reset shuts output, motor coasts
// R7: Accepted reset clears thermal and brake accumulators
// R8: Keypad reset key acts only when tripped
// R9: Loss detect settings trip after 1s absence
// R10: Other settings ignore keypad loss
// R11: Absent at power-on is no fault
// R12: Loss trip holds until reset
// R13: Keypad loss in jog decelerates motor while loss detect is not armed
// R14: RS-485 via keypad port disables loss detect
// R15: Settings 14-17 stop works every mode
// R16: Settings 0-3 stop only in keypad mode
// R17: Panel stop latches, shown, no fault output
// R18: Panel stop blocks restart until cleared
// R19: Comm keypad-mode stop enters panel stop
// R20: Too-close gain and bias gives write error
// R21: Operator releases starts before restart
// R22: Absence timer counts, clears, flags overrun
`timescale 1ns/1ps
module reset_keypad_supervisor
	import rks_pkg::*;
#(
	parameter int LOSS_LIMIT = LOSS_CYCLES, // Absence limit in cycles
	parameter int FREQ_W = 16, // Calibration frequency width
	parameter logic [15:0] MIN_GAP = 16'h0064 // Least gain-bias spacing
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Supervision setting write port
	input wire logic sup_wr,
	input wire logic [4:0] sup_wdata,
	input wire logic param_clear,
	output logic [4:0] supervision_setting,
	output logic sup_wr_reject,
	// Reset sources
	input wire logic external_reset_input,
	input wire logic comm_reset_cmd,
	input wire logic keypad_reset_key,
	// Keypad and operation mode
	input wire logic keypad_unit_present,
	input wire logic keypad_stop_key,
	input wire logic panel_stop_key,
	input wire logic stop_clear_keypad,
	input wire logic stop_clear_panel,
	input wire logic [1:0] op_mode,
	input wire logic keypad_jog,
	input wire logic rs485_via_keypad,
	input wire logic usb_via_keypad,
	// Drive state
	input wire logic fault_trip,
	input wire logic running,
	input wire logic start_request,
	// Calibration write check
	input wire logic cal_wr,
	input wire logic [FREQ_W-1:0] cal_gain_freq,
	input wire logic [FREQ_W-1:0] cal_bias_freq,
	output logic cal_write_error,
	// Drive controls
	output logic drive_reset,
	output logic output_shutoff,
	output logic accum_clear,
	output logic decel_stop,
	output logic run_enable,
	output logic tripped,
	output logic keypad_loss_fault,
	output logic fault_output,
	output logic panel_stop_state
);
	////////////////////////////////////////////////////////////////
	// Setting decode
	logic [4:0] sup_ff; // Stored setting
	logic [4:0] nxt_sup;
	logic wr_ok; // Written value is legal
	logic reset_trip_only; // Resets only when tripped
	logic loss_detect; // Loss detection chosen
	logic stop_any_mode; // Stop works in all modes
	assign wr_ok = (sup_wdata <= SUP_VAL_LO_MAX) ||
		(sup_wdata >= SUP_VAL_HI_MIN && sup_wdata <= SUP_VAL_HI_MAX); // [R2]
	// Parameter clear is deliberately ignored here [R5]
	assign nxt_sup = (sup_wr && wr_ok) ? sup_wdata : sup_ff;
	assign reset_trip_only = sup_ff[0]; // 1,3,15,17 are the odd codes [R4]
	// Low codes 2,3 carry bit 1; high codes 16,17 carry bit 4 instead.
	// Bit 1 alone would arm detection for 14 and 15, which must run on.
	assign loss_detect = stop_any_mode ? sup_ff[4] : sup_ff[1]; // [R9] [R10]
	assign stop_any_mode = sup_ff >= SUP_VAL_HI_MIN; // [R15]
	////////////////////////////////////////////////////////////////
	// Setting register; defaults to 14 and survives parameter clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sup_ff <= SUP_RESET_VALUE; // [R3]
		end else begin
			sup_ff <= nxt_sup; // [R5]
		end
	end
	assign supervision_setting = sup_ff;
	////////////////////////////////////////////////////////////////
	// Reset acceptance
	logic trip_ff; // Drive tripped (loss or external fault)
	logic any_reset_req; // Pin or comm request
	logic reset_accept; // Accepted general reset
	logic key_accept; // Accepted keypad reset key
	logic reset_now; // Any accepted reset this cycle
	assign any_reset_req = external_reset_input | comm_reset_cmd; // [R1]
	// Odd settings refuse unless tripped [R4]
	assign reset_accept = any_reset_req && (!reset_trip_only || trip_ff); // [R1]
	// Keypad key ignores the setting entirely [R8]
	assign key_accept = keypad_reset_key && trip_ff;
	assign reset_now = reset_accept | key_accept;
	////////////////////////////////////////////////////////////////
	// Keypad loss supervision
	logic loss_armed; // Detection currently live
	logic loss_expired; // Timer past limit
	// RS-485 through the keypad port kills detection [R14]
	assign loss_armed = loss_detect && !rs485_via_keypad; // [R9] [R10]
	keypad_loss_timer #(
		.LIMIT(LOSS_LIMIT)
	) u_timer (
		.clk(clk),
		.sys_rst(sys_rst),
		.present(keypad_unit_present),
		.enable(loss_armed),
		.expired(loss_expired)
	);
	logic loss_ff; // Keypad loss fault latched
	logic nxt_loss;
	logic nxt_trip;
	// Set beats clear so a new loss is never dropped [R12]
	assign nxt_loss = (loss_armed && loss_expired) ? 1'b1 : (reset_now ? 1'b0 : loss_ff);
	assign nxt_trip = (fault_trip || (loss_armed && loss_expired)) ? 1'b1 :
		(reset_now ? 1'b0 : trip_ff);
	////////////////////////////////////////////////////////////////
	// Trip and loss latches hold until an accepted reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			loss_ff <= 1'b0;
			trip_ff <= 1'b0;
		end else begin
			loss_ff <= nxt_loss; // [R9] [R12]
			trip_ff <= nxt_trip;
		end
	end
	////////////////////////////////////////////////////////////////
	// Panel stop
	logic keypad_mode;
	logic stop_req; // Stop key honoured
	logic ps_enter; // Enters latched panel stop
	logic ps_ff; // Panel stop state
	logic ps_src_ff; // 1 = panel issued it, 0 = keypad
	logic ps_clear; // Clear from issuing unit or reset pin
	logic jog_loss; // Keypad gone during jog
	assign keypad_mode = op_mode == MODE_KEYPAD;
	assign stop_req = (keypad_stop_key | panel_stop_key) &&
		(stop_any_mode || keypad_mode); // [R15] [R16]
	// Comm-driven keypad mode: panel stop key still latches [R19]
	assign ps_enter = (stop_any_mode && (keypad_stop_key | panel_stop_key)) ||
		(keypad_mode && panel_stop_key && (usb_via_keypad | rs485_via_keypad));
	assign ps_clear = (ps_src_ff ? stop_clear_panel : stop_clear_keypad) ||
		external_reset_input; // [R18]
	assign jog_loss = keypad_jog && !keypad_unit_present && !loss_armed; // [R13]
	////////////////////////////////////////////////////////////////
	// Panel stop latch; entry beats clear in the same cycle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ps_ff <= 1'b0;
			ps_src_ff <= 1'b0;
		end else if (ps_enter) begin
			ps_ff <= 1'b1; // [R17]
			ps_src_ff <= panel_stop_key;
		end else if (ps_clear) begin
			ps_ff <= 1'b0; // [R18]
		end
	end
	////////////////////////////////////////////////////////////////
	// Calibration write check; registered so the error is a clean level
	logic cal_err_ff;
	logic [FREQ_W-1:0] cal_gap;
	logic cal_close;
	assign cal_gap = (cal_gain_freq > cal_bias_freq) ? cal_gain_freq - cal_bias_freq :
		cal_bias_freq - cal_gain_freq;
	assign cal_close = cal_gap < MIN_GAP[FREQ_W-1:0]; // [R20]
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cal_err_ff <= 1'b0;
		end else if (cal_wr) begin
			cal_err_ff <= cal_close; // [R20]
		end
	end
	////////////////////////////////////////////////////////////////
	// Registered drive controls
	logic rst_pulse_ff;
	logic decel_ff;
	logic rej_ff;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rst_pulse_ff <= 1'b0;
			decel_ff <= 1'b0;
			rej_ff <= 1'b0;
		end else begin
			rst_pulse_ff <= reset_now; // [R6] [R7]
			decel_ff <= stop_req | jog_loss; // [R13] [R15] [R16]
			rej_ff <= sup_wr && !wr_ok; // [R2]
		end
	end
	// Reset coasts: shutoff, never a ramp [R6]
	assign drive_reset = rst_pulse_ff;
	assign output_shutoff = rst_pulse_ff | trip_ff;
	assign accum_clear = rst_pulse_ff; // [R7]
	assign decel_stop = decel_ff && !rst_pulse_ff;
	// Operator must drop start before clearing; we only gate it [R21]
	assign run_enable = start_request && !ps_ff && !trip_ff; // [R18]
	assign tripped = trip_ff;
	assign keypad_loss_fault = loss_ff;
	assign fault_output = trip_ff; // Panel stop never reaches here [R17]
	assign panel_stop_state = ps_ff;
	assign cal_write_error = cal_err_ff;
	assign sup_wr_reject = rej_ff;
	////////////////////////////////////////////////////////////////
	// Checks; all of them sleep while sys_rst is high
	// Setting register
	// A refused write must leave no trace in the stored code
	a_sup_legal: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
		sup_wr && !wr_ok |=> $stable(sup_ff))
		else $error("illegal setting taken");
	a_clear_keeps: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
		param_clear && !sup_wr |=> $stable(sup_ff))
		else $error("clear changed setting");

	// Reset gating and what a reset does
	// Pin and comm share one gate; the keypad key has its own
	a_trip_gate: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
		reset_trip_only && !trip_ff && !keypad_reset_key |=> !drive_reset)
		else $error("reset taken while not tripped");
	a_both_srcs: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
		(comm_reset_cmd || external_reset_input) && !reset_trip_only |=> drive_reset)
		else $error("reset request lost");
	a_key_trip: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
		keypad_reset_key && !trip_ff && !any_reset_req |=> !drive_reset)
		else $error("key reset while healthy");
	a_coast_reset: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
		drive_reset |-> output_shutoff && accum_clear && !decel_stop)
		else $error("reset did not coast");
	a_accum_clr: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
		reset_now |=> accum_clear && drive_reset)
		else $error("accumulators kept");

	// Keypad loss
	// Unarmed settings never latch; armed ones latch and hold
	a_no_loss: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
		!loss_armed && !loss_ff |=> !loss_ff)
		else $error("loss fault unarmed");
	a_loss_trip: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
		loss_armed && loss_expired |=> keypad_loss_fault && tripped)
		else $error("loss did not trip");
	a_loss_hold: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
		loss_ff && !reset_now |=> loss_ff && tripped)
		else $error("loss dropped");
	a_rs485_off: assert property (@(posedge clk) disable iff (sys_rst) // [R14]
		rs485_via_keypad |=> !loss_expired)
		else $error("loss timer ran on rs485");
	a_jog_decel: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
		jog_loss && !reset_now |=> decel_stop)
		else $error("jog loss kept running");

	// Stop keys and panel stop
	// The latch must never reach the fault output
	a_any_stop: assert property (@(posedge clk) disable iff (sys_rst) // [R15]
		stop_any_mode && (keypad_stop_key || panel_stop_key) && !reset_now
		|=> decel_stop && panel_stop_state) else $error("stop key ignored");
	a_old_stop: assert property (@(posedge clk) disable iff (sys_rst) // [R16]
		!stop_any_mode && !keypad_mode && !jog_loss |=> !decel_stop)
		else $error("stop outside keypad mode");
	a_ps_nofault: assert property (@(posedge clk) disable iff (sys_rst) // [R17]
		ps_enter && !trip_ff && !fault_trip |=> ps_ff && !fault_output)
		else $error("panel stop faulted");
	a_ps_block: assert property (@(posedge clk) disable iff (sys_rst) // [R18]
		ps_ff |-> !run_enable)
		else $error("restart in panel stop");
	a_ps_clear: assert property (@(posedge clk) disable iff (sys_rst) // [R18]
		ps_ff && external_reset_input && !ps_enter |=> !panel_stop_state)
		else $error("pin did not clear stop");

	// Calibration pair spacing
	// Error level follows the last write only
	a_cal_close: assert property (@(posedge clk) disable iff (sys_rst) // [R20]
		cal_wr && cal_close |=> cal_write_error)
		else $error("close pair accepted");

	// Main scenarios worth seeing at least once
	// Reset while running is the case that must coast
	c_loss_trip: cover property (@(posedge clk) disable iff (sys_rst) $rose(loss_ff));
	c_ps_enter: cover property (@(posedge clk) disable iff (sys_rst) $rose(ps_ff));
	c_reset: cover property (@(posedge clk) disable iff (sys_rst) drive_reset && running);
	c_cal_err: cover property (@(posedge clk) disable iff (sys_rst) $rose(cal_write_error));
	c_jog_decel: cover property (@(posedge clk) disable iff (sys_rst) jog_loss ##1 decel_stop);
endmodule // reset_keypad_supervisor

// ==== hdl/rks_pkg.sv ====
// Purpose: Shared constants for the reset and keypad supervisor
// Assumes: 25 MHz system clock
// Notes: Setting codes, timing and reset values live here
package rks_pkg;
	localparam logic [4:0] SUP_RESET_VALUE = 5'h0e; // Setting after reset
	localparam logic [4:0] SUP_VAL_LO_MAX = 5'h03; // Low range top
	localparam logic [4:0] SUP_VAL_HI_MIN = 5'h0e; // High range bottom
	localparam logic [4:0] SUP_VAL_HI_MAX = 5'h11; // High range top
	localparam int CLK_HZ = 25000000; // System clock rate
	localparam int LOSS_TIME_MS = 1000; // Keypad absence limit in ms
	localparam int LOSS_CYCLES = (CLK_HZ / 1000) * LOSS_TIME_MS; // Limit in cycles
	localparam int CLK_PERIOD_NS = 40; // Clock period
	// Operation modes
	typedef enum logic [1:0] {
		MODE_KEYPAD = 2'b00,
		MODE_EXTERNAL = 2'b01,
		MODE_NETWORK = 2'b10
	} op_mode_t;
endpackage
